/* File: ports_params.svh */
// Constants for the port 6, 7 and 8 register and pin logic
`ifndef PORTS_SIX_TO_EIGHT_PARAMS_SVH
`define PORTS_SIX_TO_EIGHT_PARAMS_SVH

`define ADDR_W 16
`define PORT6_DIR_ADDR 16'hffc9
`define PORT6_LATCH_ADDR 16'hffcb
`define PORT8_DIR_ADDR 16'hffcd
`define PORT7_LEVEL_ADDR 16'hffce
`define PORT8_LATCH_ADDR 16'hffcf

`define PORT6_DIR_RESET 8'h80
`define PORT6_LATCH_RESET 8'h80
`define PORT6_FIXED_ONES 8'h80
`define PORT8_DIR_RESET 8'he0
`define PORT8_LATCH_RESET 8'he0
`define PORT8_FIXED_ONES 8'he0
`define WRITE_ONLY_READ 8'hff
`define UNMAPPED_READ 8'h00
`define ALL_ONES_8 8'hff

`define WAIT_MODE_W 2
`define WAIT_PIN_SELECT 2'h3
`define MODE_SETTLE_EDGES 2'h2

`endif

/* File: ports_pkg.sv */
// Types and helpers shared by the port logic
package ports_pkg;

   typedef enum logic [1:0] {
      mode_unused = 2'h0,
      mode_one = 2'h1,
      mode_two = 2'h2,
      mode_three = 2'h3
   } op_mode_t;

   // Output pins read back their latch, input pins their level
   function automatic logic [7:0] read_mix(input logic [7:0] latch,
                                           input logic [7:0] level,
                                           input logic [7:0] dir);
      read_mix = (dir & latch) | (~dir & level);
   endfunction : read_mix

endpackage : ports_pkg

/* File: level_sync.sv */
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_q <= '0;
         sync_out <= '0;
      end else begin
         stage_q <= async_in;
         sync_out <= stage_q;
      end
   end
endmodule : level_sync

/* File: pin_drive.sv */
// Registered pin driver with standby handling
`timescale 1ns/1ps
module pin_drive #(
   parameter int WIDTH = 4
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic hw_standby,
   input wire logic sw_standby,
   input wire logic [WIDTH-1:0] out_d,
   input wire logic [WIDTH-1:0] oe_d,
   output logic [WIDTH-1:0] out_q,
   output logic [WIDTH-1:0] oe_q
);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= '0;
         oe_q <= '0;
      end else if (hw_standby) begin
         // Hardware standby floats every pin
         out_q <= '0;
         oe_q <= '0;
      end else if (!sw_standby) begin
         out_q <= out_d;
         oe_q <= oe_d;
      end
      // Software standby: driven pins keep their state
   end
endmodule : pin_drive

/* File: ports_six_to_eight_io.sv */
// Ports 6, 7 and 8: direction, latch, read-back and pin muxing
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "ports_params.svh"
module ports_six_to_eight_io
   import ports_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [1:0] mode_pins,
   input wire logic hw_standby_pin,
   input wire logic sw_standby,
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic bus_write_n,
   input wire logic bus_read_n,
   input wire logic addr_valid_strobe_n,
   input wire logic [`WAIT_MODE_W-1:0] bus_delay_mode,
   output logic bus_wait_n,
   input wire logic [3:0] port6_pin_in,
   output logic [3:0] port6_pin_out,
   output logic [3:0] port6_pin_oe,
   input wire logic [7:0] port7_pin_in,
   input wire logic [3:0] port8_pin_in,
   output logic [3:0] port8_pin_out,
   output logic [3:0] port8_pin_oe,
   output logic [3:0] irq_req_n
);
   // Port 6 pin vectors are ordered {bit 5, bit 4, bit 3, bit 0}

   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Pin synchronisers
   logic [1:0] mode_sync;
   logic hw_standby;
   logic [3:0] port6_level;
   logic [7:0] port7_level;
   logic [3:0] port8_level;

   level_sync #(.WIDTH(2)) u_mode_sync (
      .core_clk(core_clk),
      .rst_n(rst_n_q),
      .async_in(mode_pins),
      .sync_out(mode_sync)
   );

   level_sync #(.WIDTH(1)) u_standby_sync (
      .core_clk(core_clk),
      .rst_n(rst_n_q),
      .async_in(hw_standby_pin),
      .sync_out(hw_standby)
   );

   level_sync #(.WIDTH(4)) u_port6_sync (
      .core_clk(core_clk),
      .rst_n(rst_n_q),
      .async_in(port6_pin_in),
      .sync_out(port6_level)
   );

   // Port 7 has no direction: always sampled, in every mode
   level_sync #(.WIDTH(8)) u_port7_sync (
      .core_clk(core_clk),
      .rst_n(rst_n_q),
      .async_in(port7_pin_in),
      .sync_out(port7_level)
   );

   level_sync #(.WIDTH(4)) u_port8_sync (
      .core_clk(core_clk),
      .rst_n(rst_n_q),
      .async_in(port8_pin_in),
      .sync_out(port8_level)
   );

   // Operating mode, caught once after reset release
   // Strap synchroniser shares our reset, so wait until it has refilled
   op_mode_t mode_q;
   logic mode_taken_q;
   logic [1:0] mode_wait_q;
   wire mode_settled = (mode_wait_q == `MODE_SETTLE_EDGES);

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mode_q <= mode_unused;
         mode_taken_q <= 1'b0;
         mode_wait_q <= 2'h0;
      end else if (!mode_taken_q) begin
         if (mode_settled) begin
            mode_q <= op_mode_t'(mode_sync);
            mode_taken_q <= 1'b1;
         end else begin
            mode_wait_q <= mode_wait_q + 2'h1;
         end
      end
   end

   wire in_mode_one = (mode_q == mode_one);

   // Register decode
   wire hit_p6_dir = (reg_addr == `PORT6_DIR_ADDR);
   wire hit_p6_latch = (reg_addr == `PORT6_LATCH_ADDR);
   wire hit_p8_dir = (reg_addr == `PORT8_DIR_ADDR);
   wire hit_p7_level = (reg_addr == `PORT7_LEVEL_ADDR);
   wire hit_p8_latch = (reg_addr == `PORT8_LATCH_ADDR);

   wire wr_p6_dir = reg_wr && hit_p6_dir;
   wire wr_p6_latch = reg_wr && hit_p6_latch;
   wire wr_p8_dir = reg_wr && hit_p8_dir;
   wire wr_p8_latch = reg_wr && hit_p8_latch;

   // Software registers
   logic [7:0] port6_direction_q;
   logic [7:0] port6_output_latch_q;
   logic [7:0] port8_direction_q;
   logic [7:0] port8_output_latch_q;

   // Fixed-one bits ignore writes; the rest store the written value
   wire [7:0] port6_direction_d = reg_wdata | `PORT6_FIXED_ONES;
   wire [7:0] port6_output_latch_d = reg_wdata | `PORT6_FIXED_ONES;
   wire [7:0] port8_direction_d = reg_wdata | `PORT8_FIXED_ONES;
   wire [7:0] port8_output_latch_d = reg_wdata | `PORT8_FIXED_ONES;

   // Hardware standby reloads reset values; software standby neither reloads them nor blocks writes
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         port6_direction_q <= `PORT6_DIR_RESET;
         port6_output_latch_q <= `PORT6_LATCH_RESET;
      end else if (hw_standby) begin
         port6_direction_q <= `PORT6_DIR_RESET;
         port6_output_latch_q <= `PORT6_LATCH_RESET;
      end else begin
         if (wr_p6_dir) begin
            port6_direction_q <= port6_direction_d;
         end
         if (wr_p6_latch) begin
            port6_output_latch_q <= port6_output_latch_d;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         port8_direction_q <= `PORT8_DIR_RESET;
         port8_output_latch_q <= `PORT8_LATCH_RESET;
      end else if (hw_standby) begin
         port8_direction_q <= `PORT8_DIR_RESET;
         port8_output_latch_q <= `PORT8_LATCH_RESET;
      end else begin
         if (wr_p8_dir) begin
            port8_direction_q <= port8_direction_d;
         end
         if (wr_p8_latch) begin
            port8_output_latch_q <= port8_output_latch_d;
         end
      end
   end

   // Port 6 pin function selection
   wire [3:0] p6_dir = {port6_direction_q[5:3], port6_direction_q[0]};
   wire [3:0] p6_latch = {port6_output_latch_q[5:3],
                          port6_output_latch_q[0]};
   // Pin 0 becomes the wait input only under wait-pin operation
   wire wait_claims_pin0 = in_mode_one &&
                           (bus_delay_mode == `WAIT_PIN_SELECT);
   wire [2:0] strobe_levels = {bus_write_n, bus_read_n,
                               addr_valid_strobe_n};

   wire [3:0] p6_out_d = in_mode_one ?
                         {strobe_levels, p6_latch[0]} : p6_latch;
   // Direction bits of the strobe pins are ignored in mode 1
   wire [3:0] p6_oe_d = in_mode_one ?
                        {3'h7, p6_dir[0] & ~wait_claims_pin0} :
                        p6_dir;

   // Wait level goes to the bus controller, high when not claimed
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bus_wait_n <= 1'b1;
      end else begin
         bus_wait_n <= wait_claims_pin0 ? port6_level[0] : 1'b1;
      end
   end

   pin_drive #(.WIDTH(4)) u_port6_drive (
      .core_clk(core_clk),
      .rst_n(rst_n_q),
      .hw_standby(hw_standby),
      .sw_standby(sw_standby),
      .out_d(p6_out_d),
      .oe_d(p6_oe_d),
      .out_q(port6_pin_out),
      .oe_q(port6_pin_oe)
   );

   // Port 8 pin function selection; direction bits 7..4 unused
   wire [3:0] p8_dir = port8_direction_q[3:0];
   // Pins 3..1 forced to input in mode 1 as a guard
   wire [3:0] p8_oe_d = in_mode_one ?
                        {3'h0, p8_dir[0]} :
                        p8_dir;

   pin_drive #(.WIDTH(4)) u_port8_drive (
      .core_clk(core_clk),
      .rst_n(rst_n_q),
      .hw_standby(hw_standby),
      .sw_standby(sw_standby),
      .out_d(port8_output_latch_q[3:0]),
      .oe_d(p8_oe_d),
      .out_q(port8_pin_out),
      .oe_q(port8_pin_oe)
   );

   // Interrupt request lines follow the pin levels in any direction
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         irq_req_n <= 4'hf;
      end else begin
         irq_req_n <= port8_level;
      end
   end

   // Read-back: unused port bits present as ones when input
   wire [7:0] p6_level_full = {2'h3, port6_level[3:1], 2'h3,
                               port6_level[0]};
   wire [7:0] p8_level_full = {4'hf, port8_level};
   wire [7:0] p6_read = read_mix(port6_output_latch_q, p6_level_full,
                                 port6_direction_q);
   wire [7:0] p8_read = read_mix(port8_output_latch_q, p8_level_full,
                                 port8_direction_q);

   wire [7:0] read_sel = hit_p6_dir ? `WRITE_ONLY_READ :
                         hit_p6_latch ? p6_read :
                         hit_p8_dir ? `WRITE_ONLY_READ :
                         hit_p7_level ? port7_level :
                         hit_p8_latch ? p8_read :
                         `UNMAPPED_READ;

   // Read data stands for one cycle only, zero otherwise
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_rdata <= `UNMAPPED_READ;
      end else begin
         reg_rdata <= reg_rd ? read_sel : `UNMAPPED_READ;
      end
   end
endmodule : ports_six_to_eight_io

/* File: ports_checker_props.sv */
// Concurrent checks on the port 6, 7 and 8 block ports
`timescale 1ns/1ps
`include "ports_params.svh"
module ports_checker
   import ports_pkg::*;
(
   input logic core_clk,
   input logic rstn,
   input logic [1:0] mode_pins,
   input logic hw_standby_pin,
   input logic sw_standby,
   input logic [`ADDR_W-1:0] reg_addr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic bus_write_n,
   input logic bus_read_n,
   input logic addr_valid_strobe_n,
   input logic [`WAIT_MODE_W-1:0] bus_delay_mode,
   input logic [3:0] port6_pin_out,
   input logic [3:0] port6_pin_oe,
   input logic [7:0] port7_pin_in,
   input logic [3:0] port8_pin_in,
   input logic [3:0] port8_pin_out,
   input logic [3:0] port8_pin_oe,
   input logic [3:0] irq_req_n
);
   logic [3:0] age_q;
   logic [3:0] hw_hist_q;
   // Pin checks other than a_hwoe wait for mode capture and a quiet hardware standby
   wire ready = (age_q == 4'hf) && (hw_hist_q == 4'h0) && !hw_standby_pin;
   wire mode1 = (mode_pins == mode_one);
   wire mapped = reg_addr inside {`PORT6_DIR_ADDR, `PORT6_LATCH_ADDR,
      `PORT8_DIR_ADDR, `PORT7_LEVEL_ADDR, `PORT8_LATCH_ADDR};

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         age_q <= 4'h0;
         hw_hist_q <= 4'h0;
      end else begin
         age_q <= (age_q == 4'hf) ? age_q : age_q + 4'h1;
         hw_hist_q <= {hw_hist_q[2:0], hw_standby_pin};
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   property p_dir8;
      reg_rd && reg_addr == `PORT8_DIR_ADDR |=> reg_rdata == `WRITE_ONLY_READ;
   endproperty
   a_dir8: assert property (p_dir8)
      else $error("direction read not all ones");
   property p_unmap;
      reg_rd && !mapped |=> reg_rdata == `UNMAPPED_READ;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   property p_p7;
      reg_rd && reg_addr == `PORT7_LEVEL_ADDR |=>
         reg_rdata == $past(port7_pin_in, 3);
   endproperty
   a_p7: assert property (p_p7)
      else $error("port 7 read not pin levels");
   property p_hwoe;
      hw_standby_pin [*4] |-> (port6_pin_oe | port8_pin_oe) == 4'h0;
   endproperty
   a_hwoe: assert property (p_hwoe)
      else $error("pin driven in hardware standby");
   property p_swfrz;
      ready && $past(sw_standby) |->
         $stable(port8_pin_out) && $stable(port8_pin_oe);
   endproperty
   a_swfrz: assert property (p_swfrz)
      else $error("port 8 drive moved in software standby");
   property p_strb;
      ready && !sw_standby && mode1 |=> (&port6_pin_oe[3:1]) &&
         port6_pin_out[3:1] == $past({bus_write_n, bus_read_n,
         addr_valid_strobe_n});
   endproperty
   a_strb: assert property (p_strb)
      else $error("bus strobes not on port 6");
   property p_wclaim;
      ready && !sw_standby && mode1 && bus_delay_mode == `WAIT_PIN_SELECT
         |=> !port6_pin_oe[0];
   endproperty
   a_wclaim: assert property (p_wclaim)
      else $error("wait pin driven while claimed");
   property p_irq;
      ready |-> irq_req_n == $past(port8_pin_in, 3);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt lines not pin levels");

   c_strb: cover property (ready && mode1 && !bus_read_n);
   c_sw: cover property (ready && sw_standby && port8_pin_oe != 4'h0);
   c_p7: cover property (reg_rd && reg_addr == `PORT7_LEVEL_ADDR);
endmodule : ports_checker

bind ports_six_to_eight_io ports_checker u_chk (.core_clk, .rstn,
   .mode_pins, .hw_standby_pin, .sw_standby, .reg_addr, .reg_rd,
   .reg_rdata, .bus_write_n, .bus_read_n, .addr_valid_strobe_n,
   .bus_delay_mode, .port6_pin_out, .port6_pin_oe, .port7_pin_in,
   .port8_pin_in, .port8_pin_out, .port8_pin_oe, .irq_req_n);

/* File: board_pins.sv */
// Board side of four port pins: external driver and resolved wire
`timescale 1ns/1ps
module board_pins (
   input logic [3:0] ext,
   input logic [3:0] out,
   input logic [3:0] oe,
   output logic [3:0] level
);
   // A driving port pin wins; otherwise the board driver sets the level
   assign level = (oe & out) | (~oe & ext);
endmodule : board_pins

/* File: test_ports_six_to_eight_io.sv */
// Self-checking bench for the port 6, 7 and 8 block
`timescale 1ns/1ps
module test_ports_six_to_eight_io
   import ports_pkg::*;
;
   typedef struct packed {
      logic w;
      logic [15:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } row_t;
   logic core_clk = 1'b0, rstn = 1'b0, hw = 1'b0, sw = 1'b0;
   logic wr = 1'b0, rd = 1'b0, wait_n;
   logic [1:0] mode = 2'h2, dly = 2'h0;
   logic [2:0] strb = 3'h7;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00, p7 = 8'h3c, rdata, got;
   logic [3:0] ext6 = 4'h9, ext8 = 4'h5, lvl6, lvl8;
   logic [3:0] out6, oe6, out8, oe8, irq;
   int n_mismatch = 0, n_compared = 0;
   row_t rows [12] = '{
      '{1'b0, 16'hffcd, 8'h00, 8'hff},
      '{1'b0, 16'hffc9, 8'h00, 8'hff},
      '{1'b0, 16'hffcf, 8'h00, 8'hf5},
      '{1'b0, 16'hffcb, 8'h00, 8'he7},
      '{1'b0, 16'hffce, 8'h00, 8'h3c},
      '{1'b1, 16'hffce, 8'h00, 8'h00},
      '{1'b0, 16'hffce, 8'h00, 8'h3c},
      '{1'b0, 16'h0000, 8'h00, 8'h00},
      '{1'b1, 16'hffcf, 8'h06, 8'h00},
      '{1'b1, 16'hffcd, 8'h1c, 8'h00},
      '{1'b0, 16'hffcf, 8'h00, 8'he5},
      '{1'b0, 16'hffcd, 8'h00, 8'hff}};

   always #2.5 core_clk = ~core_clk;

   board_pins u_pins6 (.ext(ext6), .out(out6), .oe(oe6), .level(lvl6));
   board_pins u_pins8 (.ext(ext8), .out(out8), .oe(oe8), .level(lvl8));
   ports_six_to_eight_io u_dut (.core_clk(core_clk), .rstn(rstn),
      .mode_pins(mode), .hw_standby_pin(hw), .sw_standby(sw),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .bus_write_n(strb[2]), .bus_read_n(strb[1]),
      .addr_valid_strobe_n(strb[0]), .bus_delay_mode(dly),
      .bus_wait_n(wait_n), .port6_pin_in(lvl6), .port6_pin_out(out6),
      .port6_pin_oe(oe6), .port7_pin_in(p7), .port8_pin_in(lvl8),
      .port8_pin_out(out8), .port8_pin_oe(oe8), .irq_req_n(irq));

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Two cycles per access so a strobe is never dropped and raised at once
   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      wr <= 1'b0;
      rd <= 1'b0;
      // Read data stands only until the next edge; take it mid-cycle
      @(negedge core_clk);
      got = rdata;
      @(posedge core_clk);
   endtask : acc

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   task automatic do_reset(input logic [1:0] m);
      rstn <= 1'b0;
      mode <= m;
      tick(12);
      rstn <= 1'b1;
      tick(10);
   endtask : do_reset

   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   initial begin
      @(posedge core_clk);
      do_reset(2'h2);
      foreach (rows[i]) begin
         acc(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) begin
            check($sformatf("row %0d", i), got, rows[i].e);
         end
      end
      $display("register rows done");
      tick(3);
      check("p8 drive", {oe8, out8 & oe8}, 8'hc4);
      acc(1'b1, 16'hffc9, 8'h4b);
      acc(1'b1, 16'hffcb, 8'h49);
      tick(3);
      check("p6 drive", {oe6, out6 & oe6}, 8'h33);
      acc(1'b0, 16'hffcb, 8'h00);
      check("p6 read", got, 8'hed);
      p7 <= 8'ha5;
      tick(3);
      acc(1'b0, 16'hffce, 8'h00);
      check("p7 live", got, 8'ha5);
      $display("mode 2 tests done");
      sw <= 1'b1;
      acc(1'b1, 16'hffcd, 8'h00);
      tick(3);
      check("sw hold", {4'h0, oe8}, 8'h0c);
      sw <= 1'b0;
      tick(3);
      check("sw exit", {4'h0, oe8}, 8'h00);
      $display("software standby done");
      acc(1'b1, 16'hffcd, 8'h1c);
      hw <= 1'b1;
      tick(6);
      check("hw oe", {oe6, oe8}, 8'h00);
      hw <= 1'b0;
      tick(4);
      check("hw exit oe", {oe6, oe8}, 8'h00);
      acc(1'b1, 16'hffcd, 8'h1f);
      acc(1'b0, 16'hffcf, 8'h00);
      check("p8 latch reset", got, 8'he0);
      acc(1'b0, 16'hffcb, 8'h00);
      check("p6 latch reset", got, 8'he7);
      $display("hardware standby done");
      dly <= 2'h3;
      strb <= 3'h5;
      ext6 <= 4'h8;
      do_reset(2'h1);
      check("m1 oe", {4'h0, oe6}, 8'h0e);
      check("m1 strobes", {5'h0, out6[3:1]}, 8'h05);
      check("wait in", {7'h0, wait_n}, 8'h00);
      strb <= 3'h2;
      dly <= 2'h0;
      acc(1'b1, 16'hffc9, 8'h01);
      acc(1'b1, 16'hffcb, 8'h00);
      tick(3);
      check("m1 pin0", {3'h0, oe6, wait_n}, 8'h1f);
      check("m1 strobes", {5'h0, out6[3:1]}, 8'h02);
      dly <= 2'h3;
      tick(3);
      check("claim", {4'h0, oe6}, 8'h0e);
      acc(1'b1, 16'hffcf, 8'h01);
      acc(1'b1, 16'hffcd, 8'h01); // Pin 0 only
      tick(3);
      check("m1 p8", {oe8, out8 & oe8}, 8'h11);
      check("irq", {4'h0, irq}, 8'h05);
      ext8 <= 4'ha;
      tick(4);
      check("irq live", {4'h0, irq}, 8'h0b);
      $display("mode 1 tests done");
      wrap_up();
   end

   initial begin
      #20000;
      n_mismatch++;
      wrap_up();
   end
endmodule : test_ports_six_to_eight_io
